// ==== hdl/cells_pkg.sv ====
// Package for the three one-bit storage cells: value coding, timing, register map.
// Assumes a single 25 MHz core clock and a 32-bit Avalon-MM register slave.
package cells_pkg;

    // ----------------------------------------
    // Three-valued logic level
    // ----------------------------------------
    typedef enum logic [1:0] {
        LV_ZERO = 2'b00,
        LV_ONE  = 2'b01,
        LV_UNK  = 2'b10
    } lv_t;

    function automatic lv_t lv_not(input lv_t v);
        case (v)
            LV_ZERO: lv_not = LV_ONE;
            LV_ONE:  lv_not = LV_ZERO;
            default: lv_not = LV_UNK;
        endcase
    endfunction

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 40000;
    localparam int DEF_DELAY_PS  = 1000;
    localparam int MIN_DELAY_PS  = 1;
    localparam int DEF_DELAY_RAW = (DEF_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MIN_DELAY_RAW = (MIN_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] DEF_DELAY_CYC = 8'((DEF_DELAY_RAW < 1) ? 1 : DEF_DELAY_RAW);
    localparam logic [7:0] MIN_DELAY_CYC = 8'((MIN_DELAY_RAW < 1) ? 1 : MIN_DELAY_RAW);

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [4:0] TFF_DLY_OFS  = 5'h00;
    localparam logic [4:0] TFF_EDGE_OFS = 5'h04;
    localparam logic [4:0] SR_DLY_OFS   = 5'h08;
    localparam logic [4:0] SR_EDGE_OFS  = 5'h0c;
    localparam logic [4:0] LAT_DLY_OFS  = 5'h10;
    localparam logic [4:0] LAT_EDGE_OFS = 5'h14;
    localparam logic [4:0] STATUS_OFS   = 5'h18;

    // Delay word: main path, set, reset, enable (latch only)
    typedef struct packed {
        logic [7:0] enDly;
        logic [7:0] resetDly;
        logic [7:0] setDly;
        logic [7:0] mainDly;
    } dly_cfg_t;

    // Edge word: fall and rise extra delay
    typedef struct packed {
        logic [7:0] fallDly;
        logic [7:0] riseDly;
    } edge_cfg_t;

    localparam logic [31:0] FF_DLY_MASK  = 32'h00ff_ffff;
    localparam logic [31:0] FF_DLY_RST   = {8'h00, DEF_DELAY_CYC, DEF_DELAY_CYC, DEF_DELAY_CYC};
    localparam logic [31:0] LAT_DLY_RST  = {DEF_DELAY_CYC, DEF_DELAY_CYC, DEF_DELAY_CYC, DEF_DELAY_CYC};
    localparam logic [15:0] EDGE_ZERO    = 16'h0000;
    localparam logic [15:0] SR_EDGE_RST  = {DEF_DELAY_CYC, DEF_DELAY_CYC};

endpackage

// ==== hdl/lv_edge.sv ====
// Rising-edge finder for a group of three-valued inputs.
// Inputs are synchronous to core_clk; a rise is a ZERO to ONE step.
// Each input is carried as the two-bit three-valued code of the package.
`timescale 1ns/100ps
module lv_edge
    import cells_pkg::*;
#(
    parameter int N = 9
) (
    input  wire logic                core_clk,
    input  wire logic [N-1:0][1:0]   sig,
    input  wire logic                rst,
    output logic      [N-1:0]        rise
);

    logic [N-1:0][1:0] prevR;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prevR <= '0;
        end else begin
            prevR <= sig;
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            rise[i] = (prevR[i] == LV_ZERO) && (sig[i] == LV_ONE);
        end
    end

endmodule

// ==== hdl/cell_out_stage.sv ====
// Stored bit and delayed output pair of one storage cell.
// Load pulses come from the cell logic; delays are in core_clk cycles.
`timescale 1ns/100ps
module cell_out_stage
    import cells_pkg::*;
#(
    parameter int INIT_STATE = 0
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire lv_t         loadVal,
    input  wire logic [7:0]  pathDly,
    input  wire logic [7:0]  riseDly,
    input  wire logic [7:0]  fallDly,
    output lv_t              state,
    output lv_t              q,
    output lv_t              qN,
    output logic             busy
);

    localparam lv_t INIT_LV  = (INIT_STATE >= 2) ? LV_UNK : ((INIT_STATE == 1) ? LV_ONE : LV_ZERO);
    localparam lv_t INIT_LVN = (INIT_STATE >= 2) ? LV_UNK : ((INIT_STATE == 1) ? LV_ZERO : LV_ONE);

    logic [8:0] cntR;
    logic [8:0] total;
    logic [7:0] pathEff;

    // ----------------------------------------
    // Delay sum
    // ----------------------------------------
    assign pathEff = (pathDly < MIN_DELAY_CYC) ? MIN_DELAY_CYC : pathDly;
    assign total   = {1'b0, pathEff} + {1'b0, (loadVal == LV_ONE) ? riseDly : fallDly};  // see RULE_05
    assign busy    = cntR != 9'h000;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= INIT_LV;  // see RULE_06
        end else if (load) begin
            state <= loadVal;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cntR <= 9'h000;
        end else if (load) begin
            cntR <= (loadVal == LV_UNK) ? 9'h000 : total;  // see RULE_04
        end else if (cntR != 9'h000) begin
            cntR <= cntR - 9'h001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q  <= INIT_LV;
            qN <= INIT_LVN;
        end else if (load && loadVal == LV_UNK) begin
            q  <= LV_UNK;
            qN <= LV_UNK;
        end else if (!load && cntR == 9'h001) begin
            q  <= state;
            qN <= lv_not(state);  // see RULE_09
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_unk_direct: assert property (load && loadVal == LV_UNK |=> q == LV_UNK && qN == LV_UNK)  // see RULE_13
        else $error("unknown load did not reach output at once");
    a_delay_count: assert property (load && loadVal != LV_UNK |=> cntR == $past(total))  // see RULE_04
        else $error("delay count not loaded from path plus edge delay");
    a_edge_apply: assert property (cntR == 9'h001 && !load |=> q == $past(state))  // see RULE_05
        else $error("output not updated when delay expired");
    a_no_early: assert property (cntR > 9'h001 && !load |=> $stable(q))  // see RULE_04
        else $error("output changed before delay expired");
    a_out_pair: assert property (q != LV_UNK |-> qN == lv_not(q))  // see RULE_09
        else $error("complement output does not match");

endmodule

// ==== hdl/storage_cells_top.sv ====
// Toggle flip-flop, set/reset flip-flop and data latch with an Avalon-MM delay setup port.
// Cell inputs are three-valued and synchronous to core_clk; clocks of the cells are sampled.
//
// Overview of operation
// RULE_01 - Toggle cell inverts stored bit on each rising edge of its clock input; code inverts only while tffToggle is ONE.
// RULE_02 - Every cell has set and reset acting regardless of clock or enable.
// RULE_03 - Toggle cell: unknown clock, set or reset makes output unknown at once.
// RULE_04 - Flip-flops delay clock, set and reset changes by own settings, default one ns; code default is one core_clk cycle (40 ns).
// RULE_05 - Rise or fall delay, by output direction, adds to the causing path delay.
// RULE_06 - Initial output state per cell is 0, 1 or unknown, default 0.
// RULE_07 - Set/reset flip-flop captures new value on each rising clock edge from requests.
// RULE_08 - Set/reset flip-flop: unknown clock, set or reset makes output unknown at once.
// RULE_09 - Each cell drives true output and its complement.
// RULE_10 - Latch passes data to output while enable is high.
// RULE_11 - Latch holds the last passed value while enable is low.
// RULE_12 - Latch has data, enable, set and reset delays, data delay default one ns; code default is one core_clk cycle (40 ns).
// RULE_13 - Latch: any unknown input gives unknown output, except data while enable low.
// RULE_14 - Set/reset flip-flop: hold, reset gives zero, set gives one, both give unknown.
`timescale 1ns/100ps
module storage_cells_top
    import cells_pkg::*;
#(
    parameter int TFF_INIT = 0,
    parameter int SR_INIT  = 0,
    parameter int LAT_INIT = 0
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire lv_t         tffToggle,
    input  wire lv_t         tffClk,
    input  wire lv_t         tffSet,
    input  wire lv_t         tffReset,
    output lv_t              tffQ,
    output lv_t              tffQN,
    input  wire lv_t         srSetReq,
    input  wire lv_t         srResetReq,
    input  wire lv_t         srClk,
    input  wire lv_t         srSet,
    input  wire lv_t         srReset,
    output lv_t              srQ,
    output lv_t              srQN,
    input  wire lv_t         latData,
    input  wire lv_t         latEnable,
    input  wire lv_t         latSet,
    input  wire lv_t         latReset,
    output lv_t              latQ,
    output lv_t              latQN
);

    // ----------------------------------------
    // Register slave
    // ----------------------------------------
    logic      ackR;
    logic      wrHit;
    dly_cfg_t  tffDlyR;
    dly_cfg_t  srDlyR;
    dly_cfg_t  latDlyR;
    edge_cfg_t tffEdgeR;
    edge_cfg_t srEdgeR;
    edge_cfg_t latEdgeR;
    logic [2:0] busyVec;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    assign waitrequest = (read || write) && !ackR;
    assign wrHit       = write && ackR;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ackR <= 1'b0;
        end else begin
            ackR <= (read || write) && !ackR;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tffDlyR  <= FF_DLY_RST;
            srDlyR   <= FF_DLY_RST;
            latDlyR  <= LAT_DLY_RST;  // see RULE_12
            tffEdgeR <= EDGE_ZERO;
            srEdgeR  <= SR_EDGE_RST;
            latEdgeR <= EDGE_ZERO;
        end else if (wrHit) begin
            if (address == TFF_DLY_OFS) begin
                tffDlyR <= merge(tffDlyR, writedata, byteenable) & FF_DLY_MASK;
            end else if (address == TFF_EDGE_OFS) begin
                tffEdgeR <= 16'(merge({16'h0000, tffEdgeR}, writedata, byteenable));
            end else if (address == SR_DLY_OFS) begin
                srDlyR <= merge(srDlyR, writedata, byteenable) & FF_DLY_MASK;
            end else if (address == SR_EDGE_OFS) begin
                srEdgeR <= 16'(merge({16'h0000, srEdgeR}, writedata, byteenable));
            end else if (address == LAT_DLY_OFS) begin
                latDlyR <= merge(latDlyR, writedata, byteenable);
            end else if (address == LAT_EDGE_OFS) begin
                latEdgeR <= 16'(merge({16'h0000, latEdgeR}, writedata, byteenable));
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ackR) begin
            if (address == TFF_DLY_OFS) begin
                readdata <= tffDlyR;
            end else if (address == TFF_EDGE_OFS) begin
                readdata <= {16'h0000, tffEdgeR};
            end else if (address == SR_DLY_OFS) begin
                readdata <= srDlyR;
            end else if (address == SR_EDGE_OFS) begin
                readdata <= {16'h0000, srEdgeR};
            end else if (address == LAT_DLY_OFS) begin
                readdata <= latDlyR;
            end else if (address == LAT_EDGE_OFS) begin
                readdata <= {16'h0000, latEdgeR};
            end else if (address == STATUS_OFS) begin
                readdata <= {21'h000000, busyVec, 2'h0, latQ, srQ, tffQ};
            end else begin
                readdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // Edge detection of cell inputs
    // ----------------------------------------
    logic [8:0] rise;
    logic tClkRise, tSetRise, tRstRise, sClkRise, sSetRise, sRstRise, lEnRise, lSetRise, lRstRise;

    lv_edge #(.N(9)) u_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .sig      ({latReset, latSet, latEnable, srReset, srSet, srClk, tffReset, tffSet, tffClk}),
        .rise     (rise)
    );

    assign {lRstRise, lSetRise, lEnRise, sRstRise, sSetRise, sClkRise, tRstRise, tSetRise, tClkRise} = rise;

    // ----------------------------------------
    // Toggle cell
    // ----------------------------------------
    logic       tLoad;
    lv_t        tVal;
    lv_t        tState;
    logic [7:0] tDly;

    always_comb begin
        tLoad = 1'b0;
        tVal  = tState;
        tDly  = tffDlyR.mainDly;
        if (tffClk == LV_UNK || tffSet == LV_UNK || tffReset == LV_UNK) begin
            tLoad = 1'b1;  // see RULE_03
            tVal  = LV_UNK;
        end else if (tSetRise || tRstRise) begin
            tLoad = 1'b1;  // see RULE_02
            tVal  = (tffSet == LV_ONE && tffReset == LV_ONE) ? LV_UNK : (tSetRise ? LV_ONE : LV_ZERO);
            tDly  = tSetRise ? tffDlyR.setDly : tffDlyR.resetDly;
        end else if (tffSet == LV_ZERO && tffReset == LV_ZERO && tClkRise && tffToggle != LV_ZERO) begin
            tLoad = 1'b1;  // see RULE_01
            tVal  = (tffToggle == LV_UNK) ? LV_UNK : lv_not(tState);
        end
    end

    cell_out_stage #(.INIT_STATE(TFF_INIT)) u_tff (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (tLoad),
        .loadVal  (tVal),
        .pathDly  (tDly),
        .riseDly  (tffEdgeR.riseDly),
        .fallDly  (tffEdgeR.fallDly),
        .state    (tState),
        .q        (tffQ),
        .qN       (tffQN),
        .busy     (busyVec[0])
    );

    // ----------------------------------------
    // Set/reset flip-flop
    // ----------------------------------------
    logic       sLoad;
    lv_t        sVal;
    lv_t        sState;
    logic [7:0] sDly;

    always_comb begin
        sLoad = 1'b0;
        sVal  = sState;
        sDly  = srDlyR.mainDly;
        if (srClk == LV_UNK || srSet == LV_UNK || srReset == LV_UNK) begin
            sLoad = 1'b1;  // see RULE_08
            sVal  = LV_UNK;
        end else if (sSetRise || sRstRise) begin
            sLoad = 1'b1;  // see RULE_02
            sVal  = (srSet == LV_ONE && srReset == LV_ONE) ? LV_UNK : (sSetRise ? LV_ONE : LV_ZERO);
            sDly  = sSetRise ? srDlyR.setDly : srDlyR.resetDly;
        end else if (srSet == LV_ZERO && srReset == LV_ZERO && sClkRise) begin
            sLoad = 1'b1;  // see RULE_07
            if (srSetReq == LV_UNK || srResetReq == LV_UNK) begin
                sVal = LV_UNK;
            end else begin
                case ({srSetReq == LV_ONE, srResetReq == LV_ONE})  // see RULE_14
                    2'b00:   sVal = sState;
                    2'b01:   sVal = LV_ZERO;
                    2'b10:   sVal = LV_ONE;
                    default: sVal = LV_UNK;
                endcase
            end
        end
    end

    cell_out_stage #(.INIT_STATE(SR_INIT)) u_srff (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (sLoad),
        .loadVal  (sVal),
        .pathDly  (sDly),
        .riseDly  (srEdgeR.riseDly),
        .fallDly  (srEdgeR.fallDly),
        .state    (sState),
        .q        (srQ),
        .qN       (srQN),
        .busy     (busyVec[1])
    );

    // ----------------------------------------
    // Data latch
    // ----------------------------------------
    logic       lLoad;
    lv_t        lVal;
    lv_t        lState;
    logic [7:0] lDly;

    always_comb begin
        lLoad = 1'b0;  // see RULE_11
        lVal  = lState;
        lDly  = latDlyR.mainDly;
        if (latEnable == LV_UNK || latSet == LV_UNK || latReset == LV_UNK ||
            (latEnable == LV_ONE && latData == LV_UNK)) begin
            lLoad = 1'b1;  // see RULE_13
            lVal  = LV_UNK;
        end else if (lSetRise || lRstRise) begin
            lLoad = 1'b1;  // see RULE_02
            lVal  = (latSet == LV_ONE && latReset == LV_ONE) ? LV_UNK : (lSetRise ? LV_ONE : LV_ZERO);
            lDly  = lSetRise ? latDlyR.setDly : latDlyR.resetDly;
        end else if (latSet == LV_ZERO && latReset == LV_ZERO && latEnable == LV_ONE && latData != lState) begin
            lLoad = 1'b1;  // see RULE_10
            lVal  = latData;
            lDly  = lEnRise ? latDlyR.enDly : latDlyR.mainDly;  // see RULE_12
        end
    end

    cell_out_stage #(.INIT_STATE(LAT_INIT)) u_latch (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (lLoad),
        .loadVal  (lVal),
        .pathDly  (lDly),
        .riseDly  (latEdgeR.riseDly),
        .fallDly  (latEdgeR.fallDly),
        .state    (lState),
        .q        (latQ),
        .qN       (latQN),
        .busy     (busyVec[2])
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_tff_quiet;
        tffSet == LV_ZERO && tffReset == LV_ZERO && tffClk != LV_UNK && !tSetRise && !tRstRise;
    endsequence

    sequence s_bus_req;
        (read || write) && !ackR;
    endsequence

    a_tff_toggle: assert property (s_tff_quiet and (tClkRise && tffToggle == LV_ONE) |=> tState == lv_not($past(tState)))  // see RULE_01
        else $error("toggle cell did not invert on clock rise");
    a_tff_unknown: assert property (tffSet == LV_UNK || tffReset == LV_UNK |=> tffQ == LV_UNK)  // see RULE_03
        else $error("toggle cell output not unknown");
    a_async_set: assert property (sSetRise && srReset == LV_ZERO && srClk != LV_UNK |=> sState == LV_ONE)  // see RULE_02
        else $error("set did not store one");
    a_srff_capture: assert property (srSet == LV_ZERO && srReset == LV_ZERO && sClkRise && srSetReq == LV_ZERO
                                     && srResetReq == LV_ONE |=> sState == LV_ZERO)  // see RULE_14
        else $error("reset request not captured on clock rise");
    a_srff_unknown: assert property (srClk == LV_UNK |=> srQ == LV_UNK && srQN == LV_UNK)  // see RULE_08
        else $error("set/reset cell output not unknown");
    a_latch_follow: assert property (latEnable == LV_ONE && latSet == LV_ZERO && latReset == LV_ZERO
                                     && latData != LV_UNK && !lSetRise && !lRstRise |=> lState == $past(latData))  // see RULE_10
        else $error("latch not following data");
    a_latch_hold: assert property (latEnable == LV_ZERO && latSet == LV_ZERO && latReset == LV_ZERO
                                   && !lSetRise && !lRstRise |=> $stable(lState))  // see RULE_11
        else $error("latch changed while closed");
    a_latch_unknown: assert property (latEnable == LV_ONE && latData == LV_UNK |=> latQ == LV_UNK)  // see RULE_13
        else $error("latch output not unknown on unknown data");
    a_bus_answer: assert property (s_bus_req |=> !waitrequest)
        else $error("bus answer not given after one wait cycle");

endmodule

// ==== sim/clk_pulse_src.sv ====
// Partner model: surrounding logic that makes a cell clock.
// Assumes bench requests are synchronous to core_clk.
`timescale 1ns/100ps
module clk_pulse_src
    import cells_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic req,
    input  wire logic unk,
    output lv_t       cellClk
);
    // ONE for each cycle of request, one cycle late, idle ZERO
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cellClk <= LV_ZERO;
        end else if (unk) begin
            cellClk <= LV_UNK;
        end else begin
            cellClk <= req ? LV_ONE : LV_ZERO;
        end
    end
endmodule

// ==== sim/toggle_sr_flop_and_d_latch_tb.sv ====
// Self-checking bench for the three storage cells.
// Assumes the storage_cells_top ports and the cells_pkg register map.
`timescale 1ns/100ps
module toggle_sr_flop_and_d_latch_tb;
    import cells_pkg::*;
    logic core_clk, rst, read, write, tReq, tUnk, sReq, sUnk;
    logic [4:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    logic waitrequest;
    lv_t tffToggle, tffClk, tffSet, tffReset, tffQ, tffQN;
    lv_t srSetReq, srResetReq, srClk, srSet, srReset, srQ, srQN;
    lv_t latData, latEnable, latSet, latReset, latQ, latQN;
    int badCount, checkCount, cycles, n;
    lv_t sq[4] = '{LV_ZERO, LV_ZERO, LV_ONE, LV_ONE};
    lv_t rq[4] = '{LV_ONE, LV_ZERO, LV_ZERO, LV_ONE};
    lv_t ex[4] = '{LV_ZERO, LV_ZERO, LV_ONE, LV_UNK};

    storage_cells_top #(.TFF_INIT(0), .SR_INIT(1), .LAT_INIT(2)) dut (
        .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .tffToggle(tffToggle), .tffClk(tffClk), .tffSet(tffSet), .tffReset(tffReset),
        .tffQ(tffQ), .tffQN(tffQN),
        .srSetReq(srSetReq), .srResetReq(srResetReq), .srClk(srClk), .srSet(srSet), .srReset(srReset),
        .srQ(srQ), .srQN(srQN),
        .latData(latData), .latEnable(latEnable), .latSet(latSet), .latReset(latReset),
        .latQ(latQ), .latQN(latQN)
    );
    clk_pulse_src tSrc (.core_clk(core_clk), .rst(rst), .req(tReq), .unk(tUnk), .cellClk(tffClk));
    clk_pulse_src sSrc (.core_clk(core_clk), .rst(rst), .req(sReq), .unk(sUnk), .cellClk(srClk));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Avalon cycle: hold until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic settle();
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic pulse(input bit sr);
        @(posedge core_clk);
        if (sr) sReq <= 1'b1; else tReq <= 1'b1;
        @(posedge core_clk);
        sReq <= 1'b0;
        tReq <= 1'b0;
        settle();
    endtask

    // Edges from the driving edge until the chosen output shows the value
    task automatic meas(input int s, input lv_t w);
        n = 0;
        @(negedge core_clk);
        while ((s == 0 ? tffQ : latQ) !== w && n < 40) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    // ----------------------------------------
    // Clock, timeout, sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            badCount++;
            test_done();
        end
    end

    initial begin
        {rst, read, write, tReq, tUnk, sReq, sUnk} = 7'h40;
        {address, writedata, byteenable} = {5'h00, 32'h0000_0000, 4'hf};
        tffToggle = LV_ONE;
        tffSet = LV_ZERO;
        tffReset = LV_ZERO;
        srSetReq = LV_ZERO;
        srResetReq = LV_ZERO;
        srSet = LV_ZERO;
        srReset = LV_ZERO;
        latData = LV_ZERO;
        latEnable = LV_ZERO;
        latSet = LV_ZERO;
        latReset = LV_ZERO;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk(32'(tffQ), 32'(LV_ZERO));
        chk(32'(tffQN), 32'(LV_ONE));
        chk(32'(srQ), 32'(LV_ONE));
        chk(32'(latQ), 32'(LV_UNK));
        bus(1'b0, TFF_DLY_OFS, 32'h0);
        chk(rd, FF_DLY_RST);
        bus(1'b0, 5'h1c, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        pulse(1'b0);
        chk(32'(tffQ), 32'(LV_ONE));
        pulse(1'b0);
        chk(32'(tffQ), 32'(LV_ZERO));
        bus(1'b1, TFF_DLY_OFS, 32'hff00_0601);
        bus(1'b0, TFF_DLY_OFS, 32'h0);
        chk(rd, 32'h0000_0601);
        @(posedge core_clk);
        tffSet <= LV_ONE;
        meas(0, LV_ONE);
        chk(32'(n), 32'd7);
        chk(32'(tffQN), 32'(LV_ZERO));
        @(posedge core_clk);
        tffSet <= LV_ZERO;
        pulse(1'b0);
        chk(32'(tffQ), 32'(LV_ZERO));
        @(posedge core_clk);
        tUnk <= 1'b1;
        settle();
        chk(32'(tffQ), 32'(LV_UNK));
        @(posedge core_clk);
        tUnk <= 1'b0;
        @(posedge core_clk);
        tffReset <= LV_ONE;
        settle();
        chk(32'(tffQ), 32'(LV_ZERO));
        @(posedge core_clk);
        tffReset <= LV_ZERO;
        $display("toggle test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            srSetReq <= sq[i];
            srResetReq <= rq[i];
            pulse(1'b1);
            chk(32'(srQ), 32'(ex[i]));
        end
        @(posedge core_clk);
        srReset <= LV_ONE;
        settle();
        chk(32'(srQ), 32'(LV_ZERO));
        chk(32'(srQN), 32'(LV_ONE));
        @(posedge core_clk);
        srReset <= LV_ZERO;
        sUnk <= 1'b1;
        settle();
        chk(32'(srQ), 32'(LV_UNK));
        $display("set/reset test done");
        @(posedge core_clk);
        sUnk <= 1'b0;
        latEnable <= LV_ONE;
        settle();
        chk(32'(latQ), 32'(LV_ZERO));
        @(posedge core_clk);
        latEnable <= LV_ZERO;
        latData <= LV_UNK;
        settle();
        chk(32'(latQ), 32'(LV_ZERO));
        @(posedge core_clk);
        latData <= LV_ZERO;
        latEnable <= LV_ONE;
        bus(1'b1, LAT_DLY_OFS, 32'h0101_0104);
        bus(1'b1, LAT_EDGE_OFS, 32'h0000_0302);
        @(posedge core_clk);
        latData <= LV_ONE;
        meas(2, LV_ONE);
        chk(32'(n), 32'd7);
        @(posedge core_clk);
        latData <= LV_ZERO;
        meas(2, LV_ZERO);
        chk(32'(n), 32'd8);
        chk(32'(latQN), 32'(LV_ONE));
        @(posedge core_clk);
        latEnable <= LV_UNK;
        settle();
        chk(32'(latQ), 32'(LV_UNK));
        @(posedge core_clk);
        latEnable <= LV_ZERO;
        latReset <= LV_ONE;
        settle();
        chk(32'(latQ), 32'(LV_ZERO));
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h0000_0008);
        $display("latch test done");
        test_done();
    end
endmodule
